// ### rtl/gip_port.sv
`timescale 1ns/1ps
module gip_port
  import gip_pkg::*;
#(
  parameter int RX_DEPTH = 2
) (
  input logic clk, // 40 MHz system clock
  input logic srst, // Synchronous reset, high
  input logic [7:0] dio_i, // Data line levels
  output logic [7:0] dio_o, // Data line drive level
  output logic [7:0] dio_oe, // Data line pulled low
  input logic ifc_n_i, // Interface clear level
  input logic atn_n_i, // Attention level
  input logic ren_n_i, // Remote enable level
  input logic eoi_n_i, // End-or-identify level
  output logic eoi_n_o, // End-or-identify drive level
  output logic eoi_n_oe, // End-or-identify pulled low
  output logic srq_n_o, // Service request drive level
  output logic srq_n_oe, // Service request pulled low
  input logic dav_n_i, // Data valid level
  output logic dav_n_o, // Data valid drive level
  output logic dav_n_oe, // Data valid pulled low
  input logic nrfd_n_i, // Not ready level
  output logic nrfd_n_o, // Not ready drive level
  output logic nrfd_n_oe, // Not ready pulled low
  input logic ndac_n_i, // Not accepted level
  output logic ndac_n_o, // Not accepted drive level
  output logic ndac_n_oe, // Not accepted pulled low
  input logic [4:0] my_addr, // Primary bus address
  input logic [7:0] tx_data, // Byte to send
  input logic tx_end, // Byte is last of message
  input logic tx_valid, // Byte to send offered
  output logic tx_ready, // Byte to send taken
  output logic [7:0] rx_data, // Received byte
  output logic rx_end, // Received byte was last
  output logic rx_valid, // Received byte available
  input logic rx_ready, // Received byte taken
  input logic srq_req, // Device wants service
  input logic [7:0] status_in, // Serial poll status
  input logic ist, // Parallel poll status
  input logic local_req, // Front panel local key
  output logic remote, // Under bus control
  output logic lockout, // Local key locked out
  output logic listening, // Addressed to listen
  output logic talking, // Addressed to talk
  output logic serial_poll, // Serial poll mode
  output logic trig, // Trigger pulse
  output logic dev_clr // Device clear pulse
);

  logic [PIN_W-1:0] pin_s;
  logic [7:0] bus_byte;
  logic atn;
  logic ifc;
  logic ren;
  logic eoi;
  logic dav;
  logic nrfd_hi;
  logic ndac_hi;

  gip_ah_t ah_st;
  gip_sh_t sh_st;
  logic listen;
  logic talk;
  logic spmode;
  logic ppc_pend;
  logic pp_en;
  logic pp_sense;
  logic [2:0] pp_line;
  logic srq_served;
  logic srq_drv;
  logic [7:0] dio_drv;
  logic eoi_drv;
  logic [7:0] sh_byte;
  logic sh_end;
  logic sh_sp;
  logic [CNT_W-1:0] cnt;

  logic ah_take;
  logic cmd_v;
  logic [6:0] cmd;
  logic is_mla;
  logic is_mta;
  logic is_ota;
  logic is_sec;
  logic acc_on;
  logic can_take;
  logic src_on;
  logic rsv;
  logic pp_drive;
  logic sh_done;
  logic rxb_ready;

  initial begin
    if (RX_DEPTH < 2) $error("gip_port: RX_DEPTH below 2");
  end

  gip_sync #(
    .W(PIN_W)
  ) u_sync (
    .clk(clk),
    .srst(srst),
    .d({ifc_n_i, atn_n_i, ren_n_i, eoi_n_i, dav_n_i, nrfd_n_i, ndac_n_i, dio_i}),
    .q(pin_s)
  );

  // Lines are low-true: a low level is a logic one
  assign bus_byte = ~pin_s[PB_DIO +: 8];
  assign atn = ~pin_s[PB_ATN];
  assign ifc = ~pin_s[PB_IFC];
  assign ren = ~pin_s[PB_REN];
  assign eoi = ~pin_s[PB_EOI];
  assign dav = ~pin_s[PB_DAV];
  assign nrfd_hi = pin_s[PB_NRFD];
  assign ndac_hi = pin_s[PB_NDAC];

  // Command decode
  assign ah_take = (ah_st == AH_RDY) && dav;
  assign cmd_v = ah_take && atn;
  assign cmd = bus_byte[6:0];
  assign is_mla = cmd == {GRP_LAG, my_addr};
  assign is_mta = cmd == {GRP_TAG, my_addr};
  assign is_ota = (cmd[6:5] == GRP_TAG) && !is_mta && (cmd != CMD_UNT);
  assign is_sec = cmd[6:5] == GRP_SCG;

  // Acceptor handshake
  assign acc_on = atn || listen;
  assign can_take = atn || rxb_ready;

  always_ff @(posedge clk) begin
    if (srst) begin
      ah_st <= AH_IDLE;
    end else begin
      case (ah_st)
        AH_IDLE: begin
          if (acc_on) ah_st <= AH_NRDY;
        end
        AH_NRDY: begin
          if (!acc_on) ah_st <= AH_IDLE;
          else if (can_take && !dav) ah_st <= AH_RDY;
        end
        AH_RDY: begin
          if (dav) ah_st <= AH_ACPT;
          else if (!acc_on) ah_st <= AH_IDLE;
          else if (!can_take) ah_st <= AH_NRDY;
        end
        AH_ACPT: begin
          ah_st <= AH_DONE;
        end
        AH_DONE: begin
          if (!dav) ah_st <= acc_on ? AH_NRDY : AH_IDLE;
        end
        default: begin
          ah_st <= AH_IDLE;
        end
      endcase
    end
  end

  // Not-ready held through accept so it leads the accepted release
  assign nrfd_n_oe = (ah_st == AH_NRDY) || (ah_st == AH_ACPT) || (ah_st == AH_DONE);
  assign ndac_n_oe = (ah_st == AH_NRDY) || (ah_st == AH_RDY) || (ah_st == AH_ACPT);
  assign nrfd_n_o = 1'b0;
  assign ndac_n_o = 1'b0;

  gip_buf #(
    .W(9),
    .DEPTH(RX_DEPTH)
  ) u_rxbuf (
    .clk(clk),
    .srst(srst),
    .in_data({eoi, bus_byte}),
    .in_valid(ah_take && !atn),
    .in_ready(rxb_ready),
    .out_data({rx_end, rx_data}),
    .out_valid(rx_valid),
    .out_ready(rx_ready)
  );

  // Listener addressing
  always_ff @(posedge clk) begin
    if (srst || ifc) begin
      listen <= 1'b0;
    end else if (cmd_v) begin
      if (is_mla) listen <= 1'b1;
      else if (cmd == CMD_UNL || is_mta) listen <= 1'b0;
    end
  end

  // Talker addressing
  always_ff @(posedge clk) begin
    if (srst || ifc) begin
      talk <= 1'b0;
    end else if (cmd_v) begin
      if (is_mta) talk <= 1'b1;
      else if (is_ota || cmd == CMD_UNT || is_mla) talk <= 1'b0;
    end
  end

  // Serial poll mode
  always_ff @(posedge clk) begin
    if (srst || ifc) begin
      spmode <= 1'b0;
    end else if (cmd_v) begin
      if (cmd == CMD_SPE) spmode <= 1'b1;
      else if (cmd == CMD_SPD) spmode <= 1'b0;
    end
  end

  // Parallel poll configuration; secondaries keep the pending state
  always_ff @(posedge clk) begin
    if (srst || ifc) begin
      ppc_pend <= 1'b0;
    end else if (cmd_v && !is_sec) begin
      ppc_pend <= (cmd == CMD_PPC) && listen;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pp_en <= 1'b0;
      pp_sense <= 1'b0;
      pp_line <= PPL_RST;
    end else if (cmd_v) begin
      if (cmd == CMD_PPU) begin
        pp_en <= 1'b0;
      end else if (is_sec && ppc_pend) begin
        pp_en <= !cmd[PPD_BIT];
        if (!cmd[PPD_BIT]) begin
          pp_sense <= cmd[PPS_BIT];
          pp_line <= cmd[2:0];
        end
      end
    end
  end

  // Remote and local switchover
  always_ff @(posedge clk) begin
    if (srst || !ren) begin
      remote <= 1'b0;
    end else if (cmd_v && is_mla) begin
      remote <= 1'b1;
    end else if (cmd_v && cmd == CMD_GTL && listen) begin
      remote <= 1'b0;
    end else if (local_req && !lockout) begin
      remote <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !ren) begin
      lockout <= 1'b0;
    end else if (cmd_v && cmd == CMD_LLO) begin
      lockout <= 1'b1;
    end
  end

  // Trigger and clear pulses
  always_ff @(posedge clk) begin
    if (srst) begin
      trig <= 1'b0;
      dev_clr <= 1'b0;
    end else begin
      trig <= cmd_v && cmd == CMD_GET && listen;
      dev_clr <= cmd_v && (cmd == CMD_DCL || (cmd == CMD_SDC && listen));
    end
  end

  // Service request; a served request waits for srq_req to drop
  assign rsv = srq_req && !srq_served;
  assign sh_done = (sh_st == SH_XFER) && !atn && ndac_hi;

  always_ff @(posedge clk) begin
    if (srst || !srq_req) begin
      srq_served <= 1'b0;
    end else if (sh_done && sh_sp) begin
      srq_served <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) srq_drv <= 1'b0;
    else srq_drv <= rsv;
  end

  assign srq_n_oe = srq_drv;
  assign srq_n_o = 1'b0;

  // Source handshake
  assign src_on = talk && !atn;
  assign tx_ready = (sh_st == SH_IDLE) && src_on && !spmode;

  always_ff @(posedge clk) begin
    if (srst) begin
      sh_st <= SH_IDLE;
      sh_byte <= BYTE_RST;
      sh_end <= 1'b0;
      sh_sp <= 1'b0;
      cnt <= '0;
    end else begin
      case (sh_st)
        SH_IDLE: begin
          if (src_on && (spmode || tx_valid)) begin
            sh_st <= SH_SETTLE;
            sh_sp <= spmode;
            sh_end <= !spmode && tx_end;
            cnt <= CNT_W'(SETTLE_CYC);
            if (spmode) begin
              sh_byte <= {status_in[7], rsv, status_in[5:0]};
            end else begin
              sh_byte <= tx_data;
            end
          end
        end
        SH_SETTLE: begin
          if (!talk) begin
            sh_st <= SH_IDLE;
          end else if (atn) begin
            cnt <= CNT_W'(SETTLE_CYC);
          end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (nrfd_hi && !ndac_hi) begin
            sh_st <= SH_XFER;
          end
        end
        SH_XFER: begin
          if (!talk) begin
            sh_st <= SH_IDLE;
          end else if (atn) begin
            sh_st <= SH_SETTLE;
            cnt <= CNT_W'(SETTLE_CYC);
          end else if (ndac_hi) begin
            sh_st <= SH_IDLE;
          end
        end
        default: begin
          sh_st <= SH_IDLE;
        end
      endcase
    end
  end

  assign dav_n_oe = sh_st == SH_XFER;
  assign dav_n_o = 1'b0;

  // Data lines carry the talker byte or the poll answer
  assign pp_drive = atn && eoi && pp_en && (ist == pp_sense);

  always_ff @(posedge clk) begin
    if (srst) begin
      dio_drv <= BYTE_RST;
      eoi_drv <= 1'b0;
    end else begin
      eoi_drv <= src_on && sh_st != SH_IDLE && sh_end;
      if (src_on && sh_st != SH_IDLE) dio_drv <= sh_byte;
      else if (pp_drive) dio_drv <= 8'h01 << pp_line;
      else dio_drv <= BYTE_RST;
    end
  end

  assign dio_oe = dio_drv;
  assign dio_o = BYTE_RST;
  assign eoi_n_oe = eoi_drv;
  assign eoi_n_o = 1'b0;

  assign listening = listen;
  assign talking = talk;
  assign serial_poll = spmode;

endmodule : gip_port

// ### rtl/gip_pkg.sv
package gip_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned SETTLE_NS = 2000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W = $clog2(SETTLE_CYC + 1);

  // Positions in the synchronised pin vector
  localparam int unsigned PB_DIO = 0;
  localparam int unsigned PB_NDAC = 8;
  localparam int unsigned PB_NRFD = 9;
  localparam int unsigned PB_DAV = 10;
  localparam int unsigned PB_EOI = 11;
  localparam int unsigned PB_REN = 12;
  localparam int unsigned PB_ATN = 13;
  localparam int unsigned PB_IFC = 14;
  localparam int unsigned PIN_W = 15;

  // Command groups, upper two bits of a seven-bit command
  localparam logic [1:0] GRP_LAG = 2'h1;
  localparam logic [1:0] GRP_TAG = 2'h2;
  localparam logic [1:0] GRP_SCG = 2'h3;

  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_PPC = 7'h05;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_PPU = 7'h15;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;

  localparam int unsigned PPD_BIT = 4;
  localparam int unsigned PPS_BIT = 3;
  localparam int unsigned RSV_BIT = 6;

  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [2:0] PPL_RST = 3'h0;

  typedef enum logic [2:0] {AH_IDLE, AH_NRDY, AH_RDY, AH_ACPT, AH_DONE} gip_ah_t;
  typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_XFER} gip_sh_t;

endpackage : gip_pkg

// ### rtl/gip_sync.sv
`timescale 1ns/1ps
module gip_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input logic clk, // System clock
  input logic srst, // Synchronous reset
  input logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);

  logic [W-1:0] meta;

  initial begin
    if (W < 1) $error("gip_sync: W must be positive");
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : gip_sync

// ### rtl/gip_buf.sv
`timescale 1ns/1ps
module gip_buf #(
  parameter int W = 9,
  parameter int DEPTH = 2
) (
  input logic clk, // System clock
  input logic srst, // Synchronous reset
  input logic [W-1:0] in_data, // Word in
  input logic in_valid, // Word in offered
  output logic in_ready, // Room for a word
  output logic [W-1:0] out_data, // Oldest word
  output logic out_valid, // Word available
  input logic out_ready // Receiver takes word
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("gip_buf: DEPTH must be 2**n, n>=1");
  end

  assign in_ready = count != (AW + 1)'(DEPTH);
  assign out_valid = count != '0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end

endmodule : gip_buf

// ### testbench/gip_port_properties.sv
`timescale 1ns/1ps
module gip_port_properties
  import gip_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic srst, // Reset
  input wire logic [7:0] dio_oe, // Data pulls
  input wire logic eoi_n_oe, // End pull
  input wire logic ifc_n_i, // Clear level
  input wire logic ren_n_i, // Remote level
  input wire logic srq_n_oe, // Service pull
  input wire logic dav_n_i, // Valid level
  input wire logic dav_n_oe, // Valid pull
  input wire logic nrfd_n_i, // Ready level
  input wire logic nrfd_n_oe, // Ready pull
  input wire logic ndac_n_i, // Accept level
  input wire logic ndac_n_oe, // Accept pull
  input wire logic srq_req, // Service wish
  input wire logic remote, // Remote state
  input wire logic lockout, // Lockout state
  input wire logic listening, // Listen state
  input wire logic talking, // Talk state
  input wire logic serial_poll, // Poll mode
  input wire logic trig // Trigger pulse
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  sequence s_acc_reply;
    nrfd_n_oe ##1 (nrfd_n_oe && !ndac_n_oe);
  endsequence

  a_acc_reply: assert property (
    !nrfd_n_oe && ndac_n_oe && $fell(dav_n_i) |-> ##[2:4] s_acc_reply
  ) else $error("acceptor answer missing");
  a_ndac_order: assert property (
    $fell(ndac_n_oe) && !dav_n_i |-> nrfd_n_oe
  ) else $error("accept released before not-ready");
  a_dav_ready: assert property (
    $rose(dav_n_oe) |-> $past(nrfd_n_i, 3) && !$past(ndac_n_i, 3)
  ) else $error("valid without ready");
  a_dav_accept: assert property (
    $fell(dav_n_oe) |-> $past(ndac_n_i, 3)
  ) else $error("valid dropped before accept");
  a_dav_hold: assert property (
    dav_n_oe && $past(dav_n_oe) |-> $stable(dio_oe) && $stable(eoi_n_oe)
  ) else $error("data moved under valid");
  a_srq_own: assert property (
    !srq_req [*3] |-> !srq_n_oe
  ) else $error("service request without cause");
  a_ren_local: assert property (
    ren_n_i [*4] |-> ##2 !remote && !lockout
  ) else $error("remote held without enable");
  a_ifc_clear: assert property (
    !ifc_n_i [*3] |-> ##2 !listening && !talking && !serial_poll
  ) else $error("clear left addressing");
  a_trig_addr: assert property (
    trig |-> listening && !$past(trig)
  ) else $error("trigger without listener");
endmodule : gip_port_properties

bind gip_port gip_port_properties i_props (
  .clk, .srst, .dio_oe, .eoi_n_oe, .ifc_n_i, .ren_n_i, .srq_n_oe, .dav_n_i, .dav_n_oe,
  .nrfd_n_i, .nrfd_n_oe, .ndac_n_i, .ndac_n_oe, .srq_req, .remote, .lockout,
  .listening, .talking, .serial_poll, .trig
);

// ### testbench/gip_ctl_model.sv
`timescale 1ns/1ps
module gip_ctl_model
  import gip_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic [7:0] dio_oe, // Device data pulls
  input wire logic eoi_n_oe, // Device end pull
  input wire logic srq_n_oe, // Device service pull
  input wire logic dav_n_oe, // Device valid pull
  input wire logic nrfd_n_oe, // Device not-ready pull
  input wire logic ndac_n_oe, // Device not-accepted pull
  output logic [7:0] dio_i, // Data line levels
  output logic eoi_n_i, // End line
  output logic dav_n_i, // Valid line
  output logic nrfd_n_i, // Not-ready line
  output logic ndac_n_i, // Not-accepted line
  output logic atn_n_i, // Attention line
  output logic ifc_n_i, // Clear line
  output logic ren_n_i, // Remote line
  output logic srq_n // Service line
);
  // Pull flags, high pulls the line low; released lines float high
  logic [7:0] d = 8'h00;
  logic atn = 1'b0, ifc = 1'b0, ren = 1'b0, eoi = 1'b0;
  logic dav = 1'b0, nrfd = 1'b0, ndac = 1'b0;

  assign dio_i = ~(d | dio_oe);
  assign eoi_n_i = ~(eoi | eoi_n_oe);
  assign dav_n_i = ~(dav | dav_n_oe);
  assign nrfd_n_i = ~(nrfd | nrfd_n_oe);
  assign ndac_n_i = ~(ndac | ndac_n_oe);
  assign atn_n_i = ~atn;
  assign ifc_n_i = ~ifc;
  assign ren_n_i = ~ren;
  assign srq_n = ~srq_n_oe;

  task automatic send(input logic [7:0] b, input logic last);
    @(negedge clk);
    d = b;
    eoi = last;
    repeat (4) @(negedge clk);
    repeat (3000) if (!nrfd_n_i) @(negedge clk);
    dav = 1'b1;
    // Valid stands long enough for an unaddressed port to see it
    repeat (2) @(negedge clk);
    repeat (3000) if (!ndac_n_i) @(negedge clk);
    dav = 1'b0;
    @(negedge clk);
    d = 8'h00;
    eoi = 1'b0;
  endtask : send

  task automatic recv(output logic [8:0] w);
    ndac = 1'b1;
    repeat (3000) if (dav_n_i) @(negedge clk);
    w = {~eoi_n_i, ~dio_i};
    nrfd = 1'b1;
    @(negedge clk);
    ndac = 1'b0;
    repeat (3000) if (!dav_n_i) @(negedge clk);
    nrfd = 1'b0;
  endtask : recv
endmodule : gip_ctl_model

// ### testbench/gip_port_bench.sv
`timescale 1ns/1ps
module gip_port_bench;
  import gip_pkg::*;
  localparam logic [4:0] MY = 5'h0B;
  localparam logic [7:0] MLA = 8'h2B;
  localparam logic [7:0] MTA = 8'h4B;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] dio_i, dio_oe, rx_data, tx_data, status_in;
  logic ifc_n_i, atn_n_i, ren_n_i, eoi_n_i, eoi_n_oe, srq_n_oe, dav_n_i, dav_n_oe;
  logic nrfd_n_i, nrfd_n_oe, ndac_n_i, ndac_n_oe, srq_n, tx_end, tx_valid, tx_ready;
  logic rx_end, rx_valid, rx_ready, srq_req, ist, local_req, remote, lockout;
  logic listening, talking, serial_poll, trig, dev_clr;
  logic [8:0] w, st;
  int n_fail = 0, samples_checked = 0, n_trig = 0, n_clr = 0;

  assign st = {4'h0, lockout, serial_poll, listening, talking, remote};
  always #12.5 clk = ~clk;

  gip_port i_dut (.clk, .srst, .dio_i, .dio_o(), .dio_oe, .ifc_n_i, .atn_n_i, .ren_n_i,
    .eoi_n_i, .eoi_n_o(), .eoi_n_oe, .srq_n_o(), .srq_n_oe, .dav_n_i, .dav_n_o(), .dav_n_oe,
    .nrfd_n_i, .nrfd_n_o(), .nrfd_n_oe, .ndac_n_i, .ndac_n_o(), .ndac_n_oe, .my_addr(MY),
    .tx_data, .tx_end, .tx_valid, .tx_ready, .rx_data, .rx_end, .rx_valid, .rx_ready,
    .srq_req, .status_in, .ist, .local_req, .remote, .lockout, .listening, .talking,
    .serial_poll, .trig, .dev_clr);
  gip_ctl_model i_ctl (.clk, .dio_oe, .eoi_n_oe, .srq_n_oe, .dav_n_oe, .nrfd_n_oe,
    .ndac_n_oe, .dio_i, .eoi_n_i, .dav_n_i, .nrfd_n_i, .ndac_n_i, .atn_n_i, .ifc_n_i,
    .ren_n_i, .srq_n);

  always @(negedge clk) begin
    n_trig += int'(trig === 1'b1);
    n_clr += int'(dev_clr === 1'b1);
  end

  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic end_sim;
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt

  // Command byte, attention left low afterwards
  task automatic cmd(input logic [7:0] b);
    i_ctl.atn = 1'b1;
    i_ctl.send(b, 1'b0);
    wt(6);
  endtask : cmd

  task automatic pop(output logic [8:0] v);
    @(negedge clk);
    repeat (500) if (!rx_valid) @(negedge clk);
    v = {rx_end, rx_data};
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask : pop

  // Valid stays high; caller drops it after the last word
  task automatic push(input logic [7:0] b, input logic e);
    tx_data = b;
    tx_end = e;
    tx_valid = 1'b1;
    repeat (500) if (!tx_ready) @(negedge clk);
    @(negedge clk);
  endtask : push

  task automatic t_rx;
    cmd(MLA);
    chk("state", 9'h005, st);
    i_ctl.atn = 1'b0;
    wt(4);
    i_ctl.send(8'hA5, 1'b0);
    i_ctl.send(8'h3C, 1'b0);
    fork
      i_ctl.send(8'hC3, 1'b1);
      begin
        wt(40);
        chk("nrfd", 9'h000, {8'h00, nrfd_n_i});
        pop(w);
        chk("rx0", 9'h0A5, w);
        pop(w);
        chk("rx1", 9'h03C, w);
        pop(w);
        chk("rx2", 9'h1C3, w);
      end
    join
  endtask : t_rx

  task automatic t_cmd;
    cmd(8'h08);
    cmd(8'h04);
    cmd(8'h14);
    chk("trig", 9'h001, n_trig[8:0]);
    chk("clear", 9'h002, n_clr[8:0]);
    cmd(8'h11);
    chk("state", 9'h015, st);
    cmd(8'h01);
    chk("state", 9'h014, st);
    cmd(MTA);
    chk("state", 9'h012, st);
    cmd(MLA);
    chk("state", 9'h015, st);
    local_req = 1'b1;
    wt(4);
    chk("state", 9'h015, st);
    local_req = 1'b0;
    cmd(8'h3F);
    chk("state", 9'h011, st);
    cmd(MTA);
    cmd(8'h4C);
    chk("state", 9'h011, st);
    i_ctl.atn = 1'b0;
    wt(4);
    i_ctl.send(8'h5A, 1'b0);
    wt(8);
    chk("drop", 9'h000, {8'h00, rx_valid});
    i_ctl.ren = 1'b0;
    wt(8);
    chk("state", 9'h000, st);
    i_ctl.ren = 1'b1;
  endtask : t_cmd

  task automatic t_tx;
    cmd(MTA);
    i_ctl.atn = 1'b0;
    fork
      begin
        push(8'h81, 1'b0);
        push(8'h7E, 1'b1);
        tx_valid = 1'b0;
      end
      begin
        i_ctl.recv(w);
        chk("tx0", 9'h081, w);
        i_ctl.recv(w);
        chk("tx1", 9'h17E, w);
      end
    join
  endtask : t_tx

  task automatic t_spoll;
    srq_req = 1'b1;
    wt(6);
    chk("srq", 9'h000, {8'h00, srq_n});
    cmd(8'h18);
    chk("state", 9'h00A, st);
    i_ctl.atn = 1'b0;
    i_ctl.recv(w);
    chk("status", 9'h045, {1'b0, w[7:0]});
    wt(4);
    chk("srq", 9'h001, {8'h00, srq_n});
    cmd(8'h19);
    cmd(8'h5F);
    chk("state", 9'h000, st);
    srq_req = 1'b0;
  endtask : t_spoll

  task automatic t_ppoll;
    cmd(MLA);
    cmd(8'h05);
    cmd(8'h6B);
    ist = 1'b1;
    i_ctl.eoi = 1'b1;
    wt(6);
    chk("ppoll", 9'h0F7, {1'b0, dio_i});
    ist = 1'b0;
    wt(6);
    chk("ppoll", 9'h0FF, {1'b0, dio_i});
    i_ctl.eoi = 1'b0;
    wt(2);
    cmd(8'h70);
    ist = 1'b1;
    i_ctl.eoi = 1'b1;
    wt(6);
    chk("ppoll", 9'h0FF, {1'b0, dio_i});
    i_ctl.eoi = 1'b0;
    wt(2);
    cmd(8'h6B);
    i_ctl.eoi = 1'b1;
    wt(6);
    chk("ppoll", 9'h0F7, {1'b0, dio_i});
    i_ctl.eoi = 1'b0;
    wt(2);
    cmd(8'h15);
    i_ctl.eoi = 1'b1;
    wt(6);
    chk("ppoll", 9'h0FF, {1'b0, dio_i});
    i_ctl.eoi = 1'b0;
  endtask : t_ppoll

  task automatic t_ifc;
    i_ctl.ifc = 1'b1;
    wt(6);
    i_ctl.ifc = 1'b0;
    wt(4);
    chk("state", 9'h001, st);
    local_req = 1'b1;
    wt(4);
    chk("state", 9'h000, st);
    local_req = 1'b0;
  endtask : t_ifc

  initial begin
    #2_000_000;
    n_fail++;
    end_sim();
  end

  initial begin
    tx_data = 8'h00;
    tx_end = 1'b0;
    tx_valid = 1'b0;
    rx_ready = 1'b0;
    srq_req = 1'b0;
    status_in = 8'h05;
    ist = 1'b0;
    local_req = 1'b0;
    wt(3);
    srst = 1'b0;
    i_ctl.ren = 1'b1;
    wt(4);
    chk("state", 9'h000, st);
    t_rx();
    t_cmd();
    t_tx();
    t_spoll();
    t_ppoll();
    t_ifc();
    end_sim();
  end
endmodule : gip_port_bench
